// ==== hw/iarm_alias_remap_mailbox.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - each alias slot stores a 7-bit alias in bits 7..1, read/write.
// - every local transaction address is compared with each alias slot.
// - on a match the slot's physical target address replaces the alias.
// - an alias field of zero never matches.
// - all alias slots reset to zero, disabled until programmed.
// - each mailbox is plain 8-bit read/write storage with no side effect.
// - mailboxes are reachable from controllers on both link ends.
// - first mailbox at offset 0x18 resets to zero.
// - second mailbox at offset 0x19 resets to one.
// - paired target-address holds 7-bit physical address in bits 7..1.
module iarm_alias_remap_mailbox
  import iarm_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // local control port register access
  input  iarm_reg_req_t   loc_req,
  input  wire logic       loc_rd,
  output logic [7:0]      loc_rdata,
  // remote end register access over the back channel
  input  iarm_reg_req_t   rem_req,
  input  wire logic       rem_rd,
  output logic [7:0]      rem_rdata,
  // physical target addresses of slots 4..7, bits 7..1 each
  input  wire logic [4*8-1:0] remote_physical_addr,
  // local transaction address
  input  wire logic       txn_valid,
  input  wire logic [6:0] txn_addr,
  // forwarded transaction toward the remote serializer
  output logic            fwd_valid,
  output logic [6:0]      fwd_addr,
  output logic [1:0]      fwd_slot
);

  logic [6:0] alias_addr_r [N_SLOT];
  logic [7:0] msg_box_a_r;
  logic [7:0] msg_box_b_r;
  logic [4*7-1:0] alias_flat;
  logic [4*7-1:0] phys_flat;
  iarm_remap_t    remap;

  // offset decode shared by both access ports
  function automatic int slot_of(input logic [7:0] ofs);
    if (ofs >= OFS_ALIAS_SLOT4 && ofs <= OFS_ALIAS_SLOT7)
      return int'(ofs - OFS_ALIAS_SLOT4);
    return -1;
  endfunction : slot_of

  // read mux; reserved bit 0 of alias regs reads zero
  function automatic logic [7:0] rd_mux(input logic [7:0] ofs,
                                        input logic [6:0] a0,
                                        input logic [6:0] a1,
                                        input logic [6:0] a2,
                                        input logic [6:0] a3,
                                        input logic [7:0] ma,
                                        input logic [7:0] mb);
    unique case (ofs)
      OFS_ALIAS_SLOT4: return {a0, 1'b0};
      OFS_ALIAS_SLOT5: return {a1, 1'b0};
      OFS_ALIAS_SLOT6: return {a2, 1'b0};
      OFS_ALIAS_SLOT7: return {a3, 1'b0};
      OFS_MSG_BOX_A:   return ma;
      OFS_MSG_BOX_B:   return mb;
      default:         return 8'h00;
    endcase
  endfunction : rd_mux

  // alias slots; local write wins when both ends write the same slot
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < N_SLOT; i++)
        alias_addr_r[i] <= RST_ALIAS[ADDR_MSB:ADDR_LSB];
    end else begin
      for (int i = 0; i < N_SLOT; i++) begin
        if (loc_req.wr && slot_of(loc_req.ofs) == i)
          alias_addr_r[i] <= loc_req.wdata[ADDR_MSB:ADDR_LSB];
        else if (rem_req.wr && slot_of(rem_req.ofs) == i)
          alias_addr_r[i] <= rem_req.wdata[ADDR_MSB:ADDR_LSB];
      end
    end
  end

  // first mailbox, written from either end of the link
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      msg_box_a_r <= RST_MSG_BOX_A;
    else if (loc_req.wr && loc_req.ofs == OFS_MSG_BOX_A)
      msg_box_a_r <= loc_req.wdata;
    else if (rem_req.wr && rem_req.ofs == OFS_MSG_BOX_A)
      msg_box_a_r <= rem_req.wdata;
  end

  // second mailbox resets to one, not zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      msg_box_b_r <= RST_MSG_BOX_B;
    else if (loc_req.wr && loc_req.ofs == OFS_MSG_BOX_B)
      msg_box_b_r <= loc_req.wdata;
    else if (rem_req.wr && rem_req.ofs == OFS_MSG_BOX_B)
      msg_box_b_r <= rem_req.wdata;
  end

  // registered read data for each end; holds until next read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      loc_rdata <= 8'h00;
      rem_rdata <= 8'h00;
    end else begin
      if (loc_rd)
        loc_rdata <= rd_mux(loc_req.ofs, alias_addr_r[0], alias_addr_r[1],
                            alias_addr_r[2], alias_addr_r[3],
                            msg_box_a_r, msg_box_b_r);
      if (rem_rd)
        rem_rdata <= rd_mux(rem_req.ofs, alias_addr_r[0], alias_addr_r[1],
                            alias_addr_r[2], alias_addr_r[3],
                            msg_box_a_r, msg_box_b_r);
    end
  end

  // flatten tables; physical address sits in bits 7..1 of each byte
  genvar g;
  generate
    for (g = 0; g < N_SLOT; g++) begin : g_flat
      assign alias_flat[g*7 +: 7] = alias_addr_r[g];
      assign phys_flat[g*7 +: 7]  =
        remote_physical_addr[g*8+ADDR_LSB +: 7];
    end
  endgenerate

  iarm_alias_match u_match (
    .alias_flat (alias_flat),
    .phys_flat  (phys_flat),
    .addr_in    (txn_addr),
    .remap      (remap)
  );

  // forward remapped address one cycle after the request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fwd_valid <= 1'b0;
      fwd_addr  <= 7'h00;
      fwd_slot  <= 2'h0;
    end else begin
      fwd_valid <= txn_valid && remap.hit;
      if (txn_valid && remap.hit) begin
        fwd_addr <= remap.addr;
        fwd_slot <= remap.slot;
      end
    end
  end

  // assertions
  a_zero_never_fwd: assert property (
    @(posedge clk) disable iff (reset)
    txn_valid && txn_addr == 7'h00 |=> !fwd_valid)
    else $error("zero address forwarded");

  // the physical table is a level input, so its present value is compared;
  // a past slot index would point at the previous hit's entry
  a_fwd_phys_addr: assert property (
    @(posedge clk) disable iff (reset)
    fwd_valid |->
      fwd_addr == remote_physical_addr[fwd_slot*8+ADDR_LSB +: 7])
    else $error("forwarded address not the slot's physical address");

  a_fwd_alias_hit: assert property (
    @(posedge clk) disable iff (reset)
    fwd_valid |-> $past(txn_addr) == alias_addr_r[fwd_slot]
                  || $past(loc_req.wr) || $past(rem_req.wr))
    else $error("forward without alias match");

  a_alias_rsv_bit: assert property (
    @(posedge clk) disable iff (reset)
    $past(loc_rd) && slot_of($past(loc_req.ofs)) >= 0
      |-> loc_rdata[0] == 1'b0)
    else $error("reserved alias bit read nonzero");

  // bit 0 is left to a_alias_rsv_bit, so only the address field is compared
  a_alias_wr_rd: assert property (
    @(posedge clk) disable iff (reset)
    loc_req.wr && slot_of(loc_req.ofs) >= 0 && !loc_rd
      ##1 loc_rd && loc_req.ofs == $past(loc_req.ofs)
      |=> (loc_rdata >> ADDR_LSB) ==
          ($past(loc_req.wdata, 2) >> ADDR_LSB))
    else $error("alias write not read back");

  a_box_a_store: assert property (
    @(posedge clk) disable iff (reset)
    loc_req.wr && loc_req.ofs == OFS_MSG_BOX_A
      |=> msg_box_a_r == $past(loc_req.wdata))
    else $error("mailbox a did not store");

  a_box_b_hold: assert property (
    @(posedge clk) disable iff (reset)
    !(loc_req.wr && loc_req.ofs == OFS_MSG_BOX_B) &&
    !(rem_req.wr && rem_req.ofs == OFS_MSG_BOX_B)
      |=> $stable(msg_box_b_r))
    else $error("mailbox b changed without write");

  a_box_remote_wr: assert property (
    @(posedge clk) disable iff (reset)
    rem_req.wr && !loc_req.wr && rem_req.ofs == OFS_MSG_BOX_B
      |=> msg_box_b_r == $past(rem_req.wdata))
    else $error("remote mailbox write lost");

  // no disable here: it must look at the first edge after release
  a_reset_values: assert property (
    @(posedge clk)
    $fell(reset) |-> msg_box_b_r == RST_MSG_BOX_B &&
      msg_box_a_r == RST_MSG_BOX_A && alias_addr_r[0] == 7'h00)
    else $error("reset values wrong");

endmodule : iarm_alias_remap_mailbox

// ==== pkg/iarm_pkg.sv ====
package iarm_pkg;

  // register offsets on the control port
  localparam logic [7:0] OFS_ALIAS_SLOT4 = 8'h14;
  localparam logic [7:0] OFS_ALIAS_SLOT5 = 8'h15;
  localparam logic [7:0] OFS_ALIAS_SLOT6 = 8'h16;
  localparam logic [7:0] OFS_ALIAS_SLOT7 = 8'h17;
  localparam logic [7:0] OFS_MSG_BOX_A   = 8'h18;
  localparam logic [7:0] OFS_MSG_BOX_B   = 8'h19;

  // field layout: 7-bit address in bits 7..1, bit 0 reserved
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
  localparam int N_SLOT   = 4;
  localparam int SLOT_BASE = 4;

  // reset values
  localparam logic [7:0] RST_ALIAS     = 8'h00;
  localparam logic [7:0] RST_MSG_BOX_A = 8'h00;
  localparam logic [7:0] RST_MSG_BOX_B = 8'h01;
  localparam logic [6:0] ADDR_NONE     = 7'h00;

  // register access from either end of the link
  typedef struct packed {
    logic       wr;
    logic [7:0] ofs;
    logic [7:0] wdata;
  } iarm_reg_req_t;

  // remap result for a local transaction address: hit, slot and remapped form
  typedef struct packed {
    logic       hit;
    logic [1:0] slot;
    logic [6:0] addr;
  } iarm_remap_t;

endpackage : iarm_pkg

// ==== hw/iarm_alias_match.sv ====
`timescale 1ns/1ps
module iarm_alias_match
  import iarm_pkg::*;
(
  // slot tables
  input  wire logic [4*7-1:0] alias_flat,
  input  wire logic [4*7-1:0] phys_flat,
  // incoming address
  input  wire logic [6:0]     addr_in,
  // result
  output iarm_remap_t         remap
);

  logic [N_SLOT-1:0] hit_vec;

  // zero alias disables the slot
  genvar g;
  generate
    for (g = 0; g < N_SLOT; g++) begin : g_cmp
      assign hit_vec[g] = (alias_flat[g*7 +: 7] != ADDR_NONE) &&
                          (alias_flat[g*7 +: 7] == addr_in);
    end
  endgenerate

  // lowest slot wins if software programs two equal aliases
  always_comb begin
    remap = '0;
    for (int i = N_SLOT - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        remap.hit  = 1'b1;
        remap.slot = 2'(i);
        remap.addr = phys_flat[i*7 +: 7];
      end
    end
  end

endmodule : iarm_alias_match

// ==== tb/iarm_far_model.sv ====
`timescale 1ns/1ps
// far side: target-address table of the remote targets and a tally of
// transactions that reach the remote serializer
module iarm_far_model
  import iarm_pkg::*;
(
  // clock
  input  wire logic        clk,
  // forwarded transactions
  input  wire logic        fwd_valid,
  // physical addresses of slots 4..7
  output logic [4*8-1:0]   phys_flat,
  output int               n_fwd
);
  // bit 0 set on purpose so a design that leaks it shows a wrong address
  assign phys_flat = {8'hA7, 8'hA5, 8'hA3, 8'hA1};

  // one remote access per forwarded pulse; int starts at zero, one driver
  always @(posedge clk) begin
    if (fwd_valid === 1'b1) n_fwd <= n_fwd + 1;
  end
endmodule : iarm_far_model

// ==== tb/iarm_alias_remap_mailbox_tb.sv ====
`timescale 1ns/1ps
module iarm_alias_remap_mailbox_tb;
  import iarm_pkg::*;
  logic          clk, reset, loc_rd, rem_rd, txn_valid, fwd_valid;
  iarm_reg_req_t loc_req, rem_req;
  logic [7:0]    loc_rdata, rem_rdata;
  logic [31:0]   phys_flat;
  logic [6:0]    txn_addr, fwd_addr;
  logic [1:0]    fwd_slot;
  int            n_fwd, cycles, fail_count, n_compared;

  iarm_alias_remap_mailbox dut_u (.clk(clk), .reset(reset),
    .loc_req(loc_req), .loc_rd(loc_rd), .loc_rdata(loc_rdata),
    .rem_req(rem_req), .rem_rd(rem_rd), .rem_rdata(rem_rdata),
    .remote_physical_addr(phys_flat), .txn_valid(txn_valid),
    .txn_addr(txn_addr), .fwd_valid(fwd_valid), .fwd_addr(fwd_addr),
    .fwd_slot(fwd_slot));
  iarm_far_model far_u (.clk(clk), .fwd_valid(fwd_valid),
    .phys_flat(phys_flat), .n_fwd(n_fwd));

  always #20 clk = ~clk;

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  // hang guard: the whole sequence needs well under 200 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      $display("MISMATCH t=%0t timeout", $time);
      results();
    end
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  // every task starts and ends 1 ns after a rising edge, with an idle edge
  // last so a strobe is never dropped and raised in one time step
  task automatic reg_wr(input bit rem, input logic [7:0] o, d);
    if (rem) rem_req = '{1'b1, o, d};
    else loc_req = '{1'b1, o, d};
    @(posedge clk);
    #1 loc_req.wr = 1'b0;
    rem_req.wr = 1'b0;
    @(posedge clk);
    #1;
  endtask : reg_wr

  task automatic reg_rd(input bit rem, input logic [7:0] o, exp);
    if (rem) rem_req.ofs = o;
    else loc_req.ofs = o;
    rem_rd = rem;
    loc_rd = !rem;
    @(posedge clk);
    #1 loc_rd = 1'b0;
    rem_rd = 1'b0;
    cmp(rem ? rem_rdata : loc_rdata, exp);
    @(posedge clk);
    #1;
  endtask : reg_rd

  // local write, then a read of the same offset on the very next edge
  task automatic reg_wr_rd(input logic [7:0] o, d, exp);
    loc_req = '{1'b1, o, d};
    @(posedge clk);
    #1 loc_req.wr = 1'b0;
    loc_rd = 1'b1;
    @(posedge clk);
    #1 loc_rd = 1'b0;
    cmp(loc_rdata, exp);
    @(posedge clk);
    #1;
  endtask : reg_wr_rd

  task automatic txn(input logic [6:0] a, input bit hit,
                     input logic [6:0] pa, input logic [1:0] s);
    txn_valid = 1'b1;
    txn_addr = a;
    @(posedge clk);
    #1 txn_valid = 1'b0;
    cmp({7'h00, fwd_valid}, {7'h00, hit});
    if (hit) cmp({1'b0, fwd_addr}, {1'b0, pa});
    if (hit) cmp({6'h00, fwd_slot}, {6'h00, s});
    @(posedge clk);
    #1 cmp({7'h00, fwd_valid}, 8'h00);
  endtask : txn

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    loc_req = '0;
    rem_req = '0;
    {loc_rd, rem_rd, txn_valid} = 3'b000;
    txn_addr = 7'h00;
    repeat (8) @(posedge clk);
    #1 reset = 1'b0;
    for (int i = 0; i < 4; i++) begin
      reg_rd(0, OFS_ALIAS_SLOT4 + 8'(i), RST_ALIAS);
    end
    reg_rd(0, OFS_MSG_BOX_A, 8'h00);
    reg_rd(1, OFS_MSG_BOX_B, 8'h01);
    txn(7'h00, 0, 7'h00, 2'h0);
    $display("test reset values done");
    // aliases 0x10+i written with bit 0 set, from both ends
    for (int i = 0; i < 4; i++) begin
      reg_wr(i[0], OFS_ALIAS_SLOT4 + 8'(i), 8'h21 + 8'(2 * i));
    end
    for (int i = 0; i < 4; i++) begin
      reg_rd(0, OFS_ALIAS_SLOT4 + 8'(i), 8'h20 + 8'(2 * i));
    end
    for (int i = 0; i < 4; i++) begin
      txn(7'h10 + 7'(i), 1, 7'h50 + 7'(i), 2'(i));
    end
    txn(7'h30, 0, 7'h00, 2'h0);
    $display("test alias remap done");
    reg_wr(0, OFS_ALIAS_SLOT5, 8'h01);
    txn(7'h00, 0, 7'h00, 2'h0);
    txn(7'h11, 0, 7'h00, 2'h0);
    // slot 5 enabled again, read back with no idle edge in between
    reg_wr_rd(OFS_ALIAS_SLOT5, 8'h23, 8'h22);
    txn(7'h11, 1, 7'h51, 2'h1);
    $display("test disabled slot done");
    reg_wr(0, OFS_MSG_BOX_A, 8'hA5);
    reg_rd(1, OFS_MSG_BOX_A, 8'hA5);
    reg_wr(1, OFS_MSG_BOX_B, 8'h5A);
    reg_rd(0, OFS_MSG_BOX_B, 8'h5A);
    reg_rd(0, OFS_MSG_BOX_A, 8'hA5);
    reg_wr(0, 8'h1A, 8'hFF);
    reg_rd(0, 8'h1A, 8'h00);
    txn(7'h12, 1, 7'h52, 2'h2);
    cmp(8'(n_fwd), 8'h06);
    $display("test mailbox done");
    results();
  end
endmodule : iarm_alias_remap_mailbox_tb
